/* File: src/eii_consts.svh */
/*
 Constants for the edge interrupt input block: handler numbers, status
 input numbers, timing counts and mode codes.
 Assumes a 125 MHz system clock; included by bare name.
*/
`ifndef EII_CONSTS_SVH
`define EII_CONSTS_SVH

`define EII_HANDLER_FIRST 8'h14
`define EII_HANDLER_SECOND 8'h15
`define EII_STATUS_FIRST 16'h1FA4
`define EII_STATUS_SECOND 16'h1FA5
`define EII_CLK_MHZ 125
`define EII_MAX_LATENCY_US 1000
`define EII_MAX_LATENCY_CYC (`EII_MAX_LATENCY_US * `EII_CLK_MHZ)
`define EII_CNT_W 32
`define EII_LAT_W 17
`define EII_LAT_ZERO 17'h00000
`define EII_LAT_ONE 17'h00001
`define EII_CNT_ZERO 32'h00000000
`define EII_CNT_ONE 32'h00000001
`define EII_MODE_IRQ 1'b0
`define EII_MODE_COUNT 1'b1

`endif

/* File: src/eii_pkg.sv */
/*
 Types shared by the edge interrupt input block.
 Assumes eii_consts.svh is on the include path.
*/
package eii_pkg;
    typedef enum logic [1:0] {
        EII_IDLE = 2'b00,
        EII_ISSUE = 2'b01,
        EII_WAIT = 2'b10
    } eii_state_e;
    typedef logic [7:0] eii_handler_t;
endpackage

/* File: src/eii_sync_edge.sv */
/*
 Two-flop synchroniser with rising edge detector for one field input.
 Assumes the input is asynchronous to clk_i.
*/
`timescale 1ns/1ps
module eii_sync_edge (
    // Clock and reset
    input wire logic clk_i,
    input wire logic reset_i,
    // Field side
    input wire logic pin_i,
    // Synchronised outputs
    output logic level_o,
    output logic rise_o
);
    logic meta_r;
    logic sync_r;
    logic prev_r;

    // First flop feeds only the second
    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            meta_r <= 1'b0;
            sync_r <= 1'b0;
        end else begin
            meta_r <= pin_i;
            sync_r <= meta_r;
        end
    end

    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            prev_r <= 1'b0;
        end else begin
            prev_r <= sync_r;
        end
    end

    assign level_o = sync_r;
    assign rise_o = sync_r & ~prev_r;
endmodule // eii_sync_edge

/* File: src/eii_edge_irq.sv */
/*
 Two edge-triggered interrupt inputs or one combined fast counter.
 Rising edges raise sticky status inputs, and handler start requests in interrupt mode only.
 Assumes the handler side acknowledges each start with handler_ack_i,
 and that pins are asynchronous 24 V field signals already level shifted.
*/
`timescale 1ns/1ps
`include "eii_consts.svh"

// Notes on behaviour
// [R1] Rise on first input starts handler 20, second starts handler 21.
// [R2] Handler start follows a detected edge within one millisecond.
// [R3] Source keeps each input at or below 1 kHz, 50% duty.
// [R4] Sources keep summed edge rate of both inputs at or below 1 kHz.
// [R5] Each rise sets status input 8100 or 8101, handler or not.
// [R6] Pair works as two edge interrupts or one combined fast counter.
// [R7] Restricted variant hides direct status, maps both inputs to flags.
// [R8] Inputs synchronised; a pending request held until its start issues.
module eii_edge_irq
    import eii_pkg::*;
(
    // Clock and reset
    input wire logic clk_i,
    input wire logic reset_i,
    // Field pins
    input wire logic irq_in_first_i,
    input wire logic irq_in_second_i,
    // Configuration
    input wire logic count_mode_i,
    input wire logic restricted_i,
    input wire logic map_swap_i,
    // Status input clear, one bit per input
    input wire logic status_clr_i,
    input wire logic [1:0] status_clr_sel_i,
    // Handler start handshake
    input wire logic handler_ack_i,
    output logic handler_start_o,
    output eii_handler_t event_handler_block_o,
    // Direct status inputs
    output logic status_first_o,
    output logic status_second_o,
    output logic [15:0] status_addr_first_o,
    output logic [15:0] status_addr_second_o,
    // Mapped flags
    output logic [1:0] mapped_flag_o,
    // Fast counter
    output logic [`EII_CNT_W-1:0] count_o
);
    logic lvl_first;
    logic lvl_second;
    logic rise_first;
    logic rise_second;
    logic [1:0] pend_r;
    logic [1:0] stat_r;
    logic mode_r;
    eii_state_e state_r;
    logic [`EII_LAT_W-1:0] age_r [2];

    eii_sync_edge u_first (
        .clk_i(clk_i),
        .reset_i(reset_i),
        .pin_i(irq_in_first_i),
        .level_o(lvl_first),
        .rise_o(rise_first)
    ); // [R8]

    eii_sync_edge u_second (
        .clk_i(clk_i),
        .reset_i(reset_i),
        .pin_i(irq_in_second_i),
        .level_o(lvl_second),
        .rise_o(rise_second)
    ); // [R8]

    // Mode only changes between edges to avoid splitting one event
    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            mode_r <= `EII_MODE_IRQ;
        end else if (!rise_first && !rise_second) begin
            mode_r <= count_mode_i; // [R6]
        end
    end

    // Pending requests: set wins over the issue-clear
    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            pend_r <= 2'b00;
        end else begin
            for (int i = 0; i < 2; i++) begin
                if ((i == 0 ? rise_first : rise_second)
                    && mode_r == `EII_MODE_IRQ) begin
                    pend_r[i] <= 1'b1; // [R8]
                end else if (state_r == EII_IDLE && sel_ok(i)) begin
                    pend_r[i] <= 1'b0;
                end
            end
        end
    end

    // Lowest number wins; second waits behind first
    function automatic logic sel_ok(input int idx);
        sel_ok = (idx == 0) ? pend_r[0] : (pend_r[1] && !pend_r[0]);
    endfunction

    // Handler start sequencer
    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            state_r <= EII_IDLE;
            handler_start_o <= 1'b0;
            event_handler_block_o <= 8'h00;
        end else begin
            case (state_r)
                EII_IDLE: begin
                    handler_start_o <= 1'b0;
                    if (pend_r[0]) begin
                        event_handler_block_o <= `EII_HANDLER_FIRST; // [R1]
                        handler_start_o <= 1'b1;
                        state_r <= EII_ISSUE;
                    end else if (pend_r[1]) begin
                        event_handler_block_o <= `EII_HANDLER_SECOND; // [R1]
                        handler_start_o <= 1'b1;
                        state_r <= EII_ISSUE;
                    end
                end
                EII_ISSUE: begin
                    handler_start_o <= 1'b0; // [R2]
                    state_r <= EII_WAIT;
                end
                EII_WAIT: begin
                    if (handler_ack_i) begin
                        state_r <= EII_IDLE;
                    end
                end
                default: begin
                    state_r <= EII_IDLE;
                    handler_start_o <= 1'b0;
                end
            endcase
        end
    end

    // Sticky status inputs, set whether or not a handler runs
    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            stat_r <= 2'b00;
        end else begin
            for (int i = 0; i < 2; i++) begin
                if (i == 0 ? rise_first : rise_second) begin
                    stat_r[i] <= 1'b1; // [R5]
                end else if (status_clr_i && status_clr_sel_i[i]) begin
                    stat_r[i] <= 1'b0;
                end
            end
        end
    end

    // Direct view hidden on restricted variant
    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            status_first_o <= 1'b0;
            status_second_o <= 1'b0;
            mapped_flag_o <= 2'b00;
            status_addr_first_o <= `EII_STATUS_FIRST;
            status_addr_second_o <= `EII_STATUS_SECOND;
        end else begin
            status_addr_first_o <= `EII_STATUS_FIRST; // [R5]
            status_addr_second_o <= `EII_STATUS_SECOND;
            status_first_o <= stat_r[0] & ~restricted_i; // [R7]
            status_second_o <= stat_r[1] & ~restricted_i; // [R7]
            if (restricted_i) begin
                mapped_flag_o <= map_swap_i ? {lvl_first, lvl_second}
                                            : {lvl_second, lvl_first}; // [R7]
            end else begin
                mapped_flag_o <= 2'b00;
            end
        end
    end

    // Combined counter counts rises of both inputs
    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            count_o <= `EII_CNT_ZERO;
        end else if (mode_r == `EII_MODE_COUNT) begin
            count_o <= count_o + (rise_first ? `EII_CNT_ONE : `EII_CNT_ZERO)
                + (rise_second ? `EII_CNT_ONE : `EII_CNT_ZERO); // [R6]
        end
    end

    // Age of each pending request, for the latency check
    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            age_r[0] <= `EII_LAT_ZERO;
            age_r[1] <= `EII_LAT_ZERO;
        end else begin
            for (int i = 0; i < 2; i++) begin
                age_r[i] <= pend_r[i] ? age_r[i] + `EII_LAT_ONE
                                      : `EII_LAT_ZERO;
            end
        end
    end

    sequence s_first_rise;
        rise_first && mode_r == `EII_MODE_IRQ;
    endsequence

    sequence s_first_start;
        ##[1:4] (pend_r[0] && state_r == EII_IDLE) ##1
            (handler_start_o
                && event_handler_block_o == `EII_HANDLER_FIRST);
    endsequence

    // Only from a quiet sequencer: a second-input start would delay it
    property p_first_start;
        @(posedge clk_i) disable iff (reset_i)
        (s_first_rise and (state_r == EII_IDLE && pend_r == 2'b00))
            |-> s_first_start;
    endproperty
    a_first_start: assert property (p_first_start) // [R1]
        else $error("first input rise did not start handler 20");

    property p_latency;
        @(posedge clk_i) disable iff (reset_i)
        age_r[0] < `EII_MAX_LATENCY_CYC && age_r[1] < `EII_MAX_LATENCY_CYC;
    endproperty
    a_latency: assert property (p_latency) // [R2]
        else $error("handler start exceeded one millisecond");

    property p_status_set;
        @(posedge clk_i) disable iff (reset_i)
        rise_second && !restricted_i ##1 !restricted_i |=> status_second_o;
    endproperty
    a_status_set: assert property (p_status_set) // [R5]
        else $error("status input 8101 not set after rise");

    property p_count;
        @(posedge clk_i) disable iff (reset_i)
        mode_r && rise_first && !rise_second
            |=> count_o == $past(count_o) + `EII_CNT_ONE;
    endproperty
    a_count: assert property (p_count) // [R6]
        else $error("fast counter missed an edge");

    property p_hidden;
        @(posedge clk_i) disable iff (reset_i)
        restricted_i |=> !status_first_o && !status_second_o;
    endproperty
    a_hidden: assert property (p_hidden) // [R7]
        else $error("direct status visible on restricted variant");

    property p_hold;
        @(posedge clk_i) disable iff (reset_i)
        pend_r[1] && pend_r[0] |=> pend_r[1];
    endproperty
    a_hold: assert property (p_hold) // [R8]
        else $error("pending request dropped before its start");

    property p_no_start_count;
        @(posedge clk_i) disable iff (reset_i)
        mode_r && pend_r == 2'b00 && state_r == EII_IDLE
            |=> !handler_start_o;
    endproperty
    a_no_start_count: assert property (p_no_start_count) // [R6]
        else $error("handler started in counter mode");

    property p_start_pulse;
        @(posedge clk_i) disable iff (reset_i)
        handler_start_o |=> !handler_start_o;
    endproperty
    a_start_pulse: assert property (p_start_pulse) // [R1]
        else $error("handler start held longer than one cycle");
endmodule // eii_edge_irq

/* File: sim/eii_field_src.sv */
/*
 Field signal source model driving the two interrupt pins.
 Assumes fire_i and sel_i are stable at rising clk_i edges.
*/
`timescale 1ns/1ps
module eii_field_src #(
    // Half period in clock cycles; 62500 is half of 1 ms at 125 MHz
    parameter int HALF_CYC = 62500
) (
    // Clock
    input wire logic clk_i,
    // Requests from the bench
    input wire logic fire_i,
    input wire logic sel_i,
    output logic busy_o,
    // Field pins
    output logic irq_in_first_o,
    output logic irq_in_second_o
);
    // One process drives every output; one pulse at a time over both pins
    // keeps the summed rate low
    initial begin
        busy_o = 1'b0;
        irq_in_first_o = 1'b0;
        irq_in_second_o = 1'b0;
        forever begin
            @(posedge clk_i);
            if (fire_i) begin
                busy_o = 1'b1;
                @(negedge clk_i);
                if (sel_i) begin
                    irq_in_second_o = 1'b1;
                end else begin
                    irq_in_first_o = 1'b1;
                end
                repeat (HALF_CYC) @(negedge clk_i);
                irq_in_first_o = 1'b0;
                irq_in_second_o = 1'b0;
                repeat (HALF_CYC) @(negedge clk_i);
                busy_o = 1'b0;
            end
        end
    end
endmodule // eii_field_src

/* File: sim/tb.sv */
/*
 Self-checking bench for the edge interrupt input block.
 Assumes the field source model and the design sources are compiled first.
*/
`timescale 1ns/1ps
`include "eii_consts.svh"
module tb;
    import eii_pkg::*;
    // Scaled pulse phase; real field rate would take 62500 cycles
    localparam int HALF = 20;
    logic clk_i, reset_i, first, second, count_mode, restricted, swap;
    logic clr, ack, start, st_first, st_second, fire, sel, busy;
    logic [1:0] clr_sel, mapped;
    logic [15:0] addr_first, addr_second;
    logic [31:0] count;
    eii_handler_t block;
    int n_mismatch = 0;
    int n_compared = 0;
    int n_start = 0;

    eii_field_src #(.HALF_CYC(HALF)) u_eii_field_src (.clk_i(clk_i),
        .fire_i(fire), .sel_i(sel), .busy_o(busy),
        .irq_in_first_o(first), .irq_in_second_o(second));

    eii_edge_irq u_eii_edge_irq (.clk_i(clk_i), .reset_i(reset_i),
        .irq_in_first_i(first), .irq_in_second_i(second),
        .count_mode_i(count_mode), .restricted_i(restricted),
        .map_swap_i(swap), .status_clr_i(clr), .status_clr_sel_i(clr_sel),
        .handler_ack_i(ack), .handler_start_o(start),
        .event_handler_block_o(block), .status_first_o(st_first),
        .status_second_o(st_second), .status_addr_first_o(addr_first),
        .status_addr_second_o(addr_second), .mapped_flag_o(mapped),
        .count_o(count));

    initial begin
        clk_i = 1'b0;
        forever #4 clk_i = ~clk_i;
    end

    always @(posedge clk_i) begin
        if (start === 1'b1) begin
            n_start++;
        end
    end

    task automatic check(input string name, input logic [31:0] seen,
                         input logic [31:0] exp);
        n_compared++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("CHECK FAILED %s expected %0h seen %0h", name, exp, seen);
        end
    endtask

    task automatic cyc(input int n);
        repeat (n) @(negedge clk_i);
    endtask

    task automatic pulse(input logic which);
        while (busy) @(negedge clk_i);
        fire = 1'b1;
        sel = which;
        cyc(1);
        fire = 1'b0;
    endtask

    // Bound far below the 1 ms limit, so a pass is within the latency limit too
    task automatic wait_start();
        int lat;
        lat = 0;
        while (start !== 1'b1 && lat < 300) begin
            cyc(1);
            lat++;
        end
        check("start latency", 32'(lat < 300), 32'h1);
    endtask

    task automatic ack_handler();
        cyc(2);
        ack = 1'b1;
        cyc(1);
        ack = 1'b0;
    endtask

    task automatic t_first();
        pulse(1'b0);
        wait_start();
        check("handler number", block, 32'h14);
        check("status first", st_first, 32'h1);
        check("status second", st_second, 32'h0);
        check("status addr first", addr_first, 32'h1FA4);
        check("status addr second", addr_second, 32'h1FA5);
        ack_handler();
        $display("test first_irq done");
    endtask

    task automatic t_pending();
        int s0;
        pulse(1'b0);
        wait_start();
        // Let the monitor count this start before taking the baseline
        cyc(1);
        s0 = n_start;
        pulse(1'b1);
        cyc(12);
        check("start held until ack", n_start, s0);
        check("status second", st_second, 32'h1);
        ack_handler();
        wait_start();
        check("handler number", block, 32'h15);
        ack_handler();
        $display("test pending done");
    endtask

    task automatic t_count();
        int s0;
        logic [31:0] c0;
        while (busy) cyc(1);
        count_mode = 1'b1;
        cyc(2);
        s0 = n_start;
        c0 = count;
        pulse(1'b0);
        pulse(1'b1);
        pulse(1'b0);
        while (busy) cyc(1);
        cyc(6);
        check("counted rises", count - c0, 32'h3);
        check("no handler in count mode", n_start, s0);
        $display("test counter done");
    endtask

    task automatic t_mapped();
        restricted = 1'b1;
        swap = 1'b0;
        pulse(1'b0);
        cyc(8);
        check("mapped flags plain", mapped, 32'h1);
        swap = 1'b1;
        cyc(3);
        check("mapped flags swapped", mapped, 32'h2);
        while (busy) cyc(1);
        restricted = 1'b0;
        swap = 1'b0;
        cyc(3);
        check("mapped flags off", mapped, 32'h0);
        count_mode = 1'b0;
        $display("test mapped done");
    endtask

    task automatic t_clear();
        for (int i = 1; i < 3; i++) begin
            clr_sel = 2'(i);
            clr = 1'b1;
            cyc(1);
            clr = 1'b0;
            cyc(2);
            check("status first", st_first, 32'h0);
            check("status second", st_second, 32'(i == 1));
        end
        $display("test clear done");
    endtask

    task automatic complete_run();
        $display("compared %0d mismatched %0d", n_compared, n_mismatch);
        if (n_mismatch == 0 && n_compared > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask

    initial begin
        {reset_i, count_mode, restricted, swap} = 4'h8;
        {clr, ack, fire, sel} = 4'h0;
        clr_sel = 2'h0;
        cyc(10);
        reset_i = 1'b0;
        cyc(3);
        t_first();
        t_pending();
        t_count();
        t_mapped();
        t_clear();
        complete_run();
    end

    // Tests need a few hundred cycles; this allows ample slack
    initial begin
        #200000;
        n_mismatch++;
        complete_run();
    end
endmodule // tb
